// ### rtl/i2c_target_consts.svh
// Constants for the two-wire target register port
`ifndef I2C_TARGET_CONSTS_SVH
`define I2C_TARGET_CONSTS_SVH

// --------------------------------------------------------------------
// Addressing
// --------------------------------------------------------------------
`define ADDR_PREFIX 4'h9
`define BCAST_ADDR 7'h47
`define GCALL_ADDR 7'h00
`define GCALL_RESET_BYTE 8'h06
`define ADDR_LOW_GND 3'h0
`define ADDR_LOW_VDD 3'h1
`define ADDR_LOW_SDA 3'h2
`define ADDR_LOW_SCL 3'h3
`define DIR_WRITE 1'b0

// --------------------------------------------------------------------
// Framing and timing
// --------------------------------------------------------------------
`define BITS_PER_BYTE 4'h8
`define RATE_STD_KBPS 100
`define RATE_FAST_KBPS 400
`define RATE_FAST_PLUS_KBPS 1000
`define LINK_CLK_KHZ 8000
`define MIN_SAMPLES_PER_BIT 8

`endif

// ### rtl/i2c_target_pkg.sv
// Types for the two-wire target register port
package i2c_target_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_MACK} link_state_type;

  typedef enum logic [1:0] {ROLE_CMD, ROLE_UPPER, ROLE_LOWER, ROLE_GCALL} byte_role_type;

  typedef enum logic [1:0] {LOCK_NONE, LOCK_I2C, LOCK_OTHER} lock_state_type;

endpackage

// ### rtl/i2c_target_register_port.sv
// Two-wire target port giving a bus controller access to 16-bit registers
//
// Behaviour
// R1: Works at 100k, 400k and 1M bit rates; one protocol for all.
// R2: Decodes 7-bit addresses only; 10-bit addressing never answered.
// R3: Each byte gets a ninth clock; receiver holds data low for acknowledge.
// R4: Start is data falling while clock high; detected in any state.
// R5: Stop is data rising while clock high; release bus, await start.
// R6: Transmitter changes data only while the clock is low.
// R7: Acknowledge the address byte only when the address matches.
// R8: After address, eight data bits plus acknowledge repeat while clocked.
// R9: Start, general call 00h, reset byte 06h, stop gives a soft reset.
// R10: Soft reset fires on the acknowledge rising edge after the second byte.
// R11: Write is address, command, upper and lower data bytes, each acknowledged.
// R12: Command byte selects the register to write or read.
// R13: Written value applied on the acknowledge falling edge after lower byte.
// R14: Upper four address bits fixed at 1001b; low three from select pin.
// R15: Select pin sampled over first byte: gnd, supply, data, clock ties.
// R16: Broadcast address answered for writes only, whatever the select pin.
// R17: Read: write command, repeated start with read, return upper then lower.
// R18: Lock to whichever protocol talks first; ignore others until power cycle.
// R19: Controller refuses the lower read byte then stops; target releases data.
`timescale 1ns/1ps

`include "i2c_target_consts.svh"

module i2c_target_register_port #(
  parameter int LINK_CLK_KHZ = `LINK_CLK_KHZ
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic link_clk, // Oversampling clock for the bus lines
  input wire logic scl_i, // Serial clock level seen on the bus
  input wire logic sda_i, // Serial data level seen on the bus
  output logic sda_o, // Serial data drive value, always low
  output logic sda_oe, // High while pulling serial data low
  input wire logic address_select_pin, // Address select strap level
  input wire logic other_protocol_seen, // Other host protocol became active
  output logic reg_wr_en, // One-cycle register write strobe
  output logic [7:0] reg_wr_addr, // Register selected by write
  output logic [15:0] reg_wr_data, // Value written
  output logic [7:0] reg_rd_addr, // Register selected for readback
  input wire logic [15:0] reg_rd_data, // Register value for reg_rd_addr
  output logic soft_reset, // One-cycle software reset pulse
  output logic iface_locked_i2c, // Interface locked to this port
  output logic iface_locked_other // Interface locked to the other protocol
);

  // Lowest oversampling that still sees the shortest clock-high phase
  if (LINK_CLK_KHZ < `MIN_SAMPLES_PER_BIT * `RATE_FAST_PLUS_KBPS) // R1
  begin : g_rate_check
    $error("link clock too slow for the fastest bit rate");
  end

  // A level is taken once the two later sync stages agree
  function automatic logic settle(input logic cur, input logic s2, input logic s3);
    settle = (s2 == s3) ? s3 : cur;
  endfunction

  // Low address bits from how the select pin tracked the bus lines
  function automatic logic [2:0] addr_low(input logic not_sda, input logic not_scl, input logic pin);
    if (!not_scl)
      addr_low = `ADDR_LOW_SCL;
    else if (!not_sda)
      addr_low = `ADDR_LOW_SDA;
    else if (pin)
      addr_low = `ADDR_LOW_VDD;
    else
      addr_low = `ADDR_LOW_GND;
  endfunction

  // --------------------------------------------------------------------
  // Link domain: line synchronisers and edge detection
  // --------------------------------------------------------------------
  logic [2:0] scl_s_reg;
  logic [2:0] sda_s_reg;
  logic [2:0] pin_s_reg;
  logic [2:0] en_s_reg;
  logic [2:0] rd_ack_s_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  logic pin_q_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic link_en_reg;
  logic rd_ack_q_reg;
  logic rd_ack_d_reg;
  logic lock_en_reg;
  logic rd_ack_tgl_reg;
  logic [15:0] rd_hold_reg;

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      pin_s_reg <= 3'h0;
      en_s_reg <= 3'h0;
      rd_ack_s_reg <= 3'h0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      pin_q_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      link_en_reg <= 1'b0;
      rd_ack_q_reg <= 1'b0;
      rd_ack_d_reg <= 1'b0;
    end
    else
    begin
      scl_s_reg <= {scl_s_reg[1:0], scl_i};
      sda_s_reg <= {sda_s_reg[1:0], sda_i};
      pin_s_reg <= {pin_s_reg[1:0], address_select_pin};
      en_s_reg <= {en_s_reg[1:0], lock_en_reg};
      rd_ack_s_reg <= {rd_ack_s_reg[1:0], rd_ack_tgl_reg};
      scl_q_reg <= settle(scl_q_reg, scl_s_reg[1], scl_s_reg[2]);
      sda_q_reg <= settle(sda_q_reg, sda_s_reg[1], sda_s_reg[2]);
      pin_q_reg <= settle(pin_q_reg, pin_s_reg[1], pin_s_reg[2]);
      link_en_reg <= settle(link_en_reg, en_s_reg[1], en_s_reg[2]);
      rd_ack_q_reg <= settle(rd_ack_q_reg, rd_ack_s_reg[1], rd_ack_s_reg[2]);
      scl_d_reg <= scl_q_reg;
      sda_d_reg <= sda_q_reg;
      rd_ack_d_reg <= rd_ack_q_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Both lines share one sync depth, so their order is kept
  assign scl_rise = scl_q_reg & ~scl_d_reg;
  assign scl_fall = ~scl_q_reg & scl_d_reg;
  assign start_det = scl_q_reg & scl_d_reg & sda_d_reg & ~sda_q_reg; // R4
  assign stop_det = scl_q_reg & scl_d_reg & ~sda_d_reg & sda_q_reg; // R5

  // --------------------------------------------------------------------
  // Link domain: select pin tracking over the address byte
  // --------------------------------------------------------------------
  i2c_target_pkg::link_state_type state_reg;
  logic not_sda_reg;
  logic not_scl_reg;

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      not_sda_reg <= 1'b0;
      not_scl_reg <= 1'b0;
    end
    else if (start_det)
    begin
      not_sda_reg <= 1'b0;
      not_scl_reg <= 1'b0;
    end
    else if (state_reg == i2c_target_pkg::ST_ADDR)
    begin
      if (pin_q_reg != sda_q_reg)
        not_sda_reg <= 1'b1; // R15
      if (pin_q_reg != scl_q_reg)
        not_scl_reg <= 1'b1; // R15
    end
  end

  logic [7:0] rx_shift_reg;
  logic [6:0] own_addr;
  logic addr_own;
  logic addr_bcast;
  logic addr_gcall;

  assign own_addr = {`ADDR_PREFIX, addr_low(not_sda_reg, not_scl_reg, pin_q_reg)}; // R14 R15
  assign addr_own = rx_shift_reg[7:1] == own_addr; // R2 R7
  assign addr_bcast = rx_shift_reg[7:1] == `BCAST_ADDR && rx_shift_reg[0] == `DIR_WRITE; // R16
  assign addr_gcall = rx_shift_reg[7:1] == `GCALL_ADDR && rx_shift_reg[0] == `DIR_WRITE; // R9

  // --------------------------------------------------------------------
  // Link domain: byte engine
  // --------------------------------------------------------------------
  i2c_target_pkg::byte_role_type role_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] cmd_reg;
  logic [7:0] upper_data_byte_reg;
  logic [15:0] rd_word_reg;
  logic is_read_reg;
  logic ack_addr_reg;
  logic ack_ok_reg;
  logic tx_second_reg;
  logic sda_oe_reg;
  logic seen_reg;
  logic wr_tgl_reg;
  logic rst_tgl_reg;
  logic rd_req_tgl_reg;
  logic [7:0] wr_addr_hold_reg;
  logic [15:0] wr_data_hold_reg;

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= i2c_target_pkg::ST_IDLE;
      role_reg <= i2c_target_pkg::ROLE_CMD;
      bit_cnt_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      upper_data_byte_reg <= 8'h00;
      is_read_reg <= 1'b0;
      ack_addr_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      tx_second_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      seen_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
      rst_tgl_reg <= 1'b0;
      rd_req_tgl_reg <= 1'b0;
      wr_addr_hold_reg <= 8'h00;
      wr_data_hold_reg <= 16'h0000;
    end
    else if (!link_en_reg)
    begin
      state_reg <= i2c_target_pkg::ST_IDLE; // R18
      sda_oe_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= i2c_target_pkg::ST_ADDR; // R4
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= i2c_target_pkg::ST_IDLE; // R5
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        i2c_target_pkg::ST_IDLE:
          sda_oe_reg <= 1'b0;
        i2c_target_pkg::ST_ADDR, i2c_target_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_q_reg}; // R6
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == i2c_target_pkg::ST_ADDR)
            begin
              if (addr_own || addr_bcast || addr_gcall)
              begin
                sda_oe_reg <= 1'b1; // R3 R7
                state_reg <= i2c_target_pkg::ST_ACK;
                ack_addr_reg <= 1'b1;
                seen_reg <= 1'b1; // R18
                is_read_reg <= rx_shift_reg[0];
                if (rx_shift_reg[0] == `DIR_WRITE)
                  role_reg <= addr_gcall ? i2c_target_pkg::ROLE_GCALL : i2c_target_pkg::ROLE_CMD;
              end
              else
                state_reg <= i2c_target_pkg::ST_IDLE; // R7
            end
            else if (role_reg == i2c_target_pkg::ROLE_GCALL && rx_shift_reg != `GCALL_RESET_BYTE)
              state_reg <= i2c_target_pkg::ST_IDLE;
            else
            begin
              sda_oe_reg <= 1'b1; // R3 R11
              state_reg <= i2c_target_pkg::ST_ACK;
              ack_addr_reg <= 1'b0;
              if (role_reg == i2c_target_pkg::ROLE_CMD)
              begin
                cmd_reg <= rx_shift_reg; // R12
                rd_req_tgl_reg <= ~rd_req_tgl_reg; // R17
              end
              else if (role_reg == i2c_target_pkg::ROLE_UPPER)
                upper_data_byte_reg <= rx_shift_reg;
            end
          end
        end
        i2c_target_pkg::ST_ACK:
        begin
          if (scl_rise && !ack_addr_reg && role_reg == i2c_target_pkg::ROLE_GCALL)
            rst_tgl_reg <= ~rst_tgl_reg; // R9 R10
          else if (scl_fall)
          begin
            if (ack_addr_reg && is_read_reg)
            begin
              sda_oe_reg <= ~rd_word_reg[15]; // R17
              tx_shift_reg <= {rd_word_reg[14:8], 1'b0};
              tx_second_reg <= 1'b0;
              state_reg <= i2c_target_pkg::ST_TX;
            end
            else if (!ack_addr_reg && role_reg == i2c_target_pkg::ROLE_GCALL)
            begin
              sda_oe_reg <= 1'b0;
              state_reg <= i2c_target_pkg::ST_IDLE;
            end
            else
            begin
              sda_oe_reg <= 1'b0;
              state_reg <= i2c_target_pkg::ST_RX; // R8
              if (!ack_addr_reg)
              begin
                unique case (role_reg)
                  i2c_target_pkg::ROLE_CMD:
                    role_reg <= i2c_target_pkg::ROLE_UPPER;
                  i2c_target_pkg::ROLE_UPPER:
                    role_reg <= i2c_target_pkg::ROLE_LOWER;
                  default:
                  begin
                    // Further pairs keep going to the same register
                    role_reg <= i2c_target_pkg::ROLE_UPPER;
                    wr_addr_hold_reg <= cmd_reg;
                    wr_data_hold_reg <= {upper_data_byte_reg, rx_shift_reg};
                    wr_tgl_reg <= ~wr_tgl_reg; // R13
                  end
                endcase
              end
            end
          end
        end
        i2c_target_pkg::ST_TX:
        begin
          if (scl_rise)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt_reg < `BITS_PER_BYTE)
            begin
              sda_oe_reg <= ~tx_shift_reg[7]; // R6
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
            else
            begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg <= i2c_target_pkg::ST_MACK;
            end
          end
        end
        i2c_target_pkg::ST_MACK:
        begin
          if (scl_rise)
            ack_ok_reg <= ~sda_q_reg; // R3
          else if (scl_fall)
          begin
            if (ack_ok_reg && !tx_second_reg)
            begin
              sda_oe_reg <= ~rd_word_reg[7]; // R17
              tx_shift_reg <= {rd_word_reg[6:0], 1'b0};
              tx_second_reg <= 1'b1;
              state_reg <= i2c_target_pkg::ST_TX;
            end
            else
              state_reg <= i2c_target_pkg::ST_IDLE; // R19
          end
        end
        default:
          state_reg <= i2c_target_pkg::ST_IDLE;
      endcase
    end
  end

  // Read word is copied only after the system side has settled it
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_word_reg <= 16'h0000;
    else if (rd_ack_q_reg != rd_ack_d_reg)
      rd_word_reg <= rd_hold_reg; // R17
  end

  // --------------------------------------------------------------------
  // System domain: event crossings
  // --------------------------------------------------------------------
  logic [2:0] wr_s_reg;
  logic [2:0] rst_s_reg;
  logic [2:0] rd_s_reg;
  logic [2:0] seen_s_reg;
  logic wr_q_reg;
  logic rst_q_reg;
  logic rd_q_reg;
  logic seen_q_reg;
  logic wr_d_reg;
  logic rst_d_reg;
  logic rd_d_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_s_reg <= 3'h0;
      rst_s_reg <= 3'h0;
      rd_s_reg <= 3'h0;
      seen_s_reg <= 3'h0;
      wr_q_reg <= 1'b0;
      rst_q_reg <= 1'b0;
      rd_q_reg <= 1'b0;
      seen_q_reg <= 1'b0;
      wr_d_reg <= 1'b0;
      rst_d_reg <= 1'b0;
      rd_d_reg <= 1'b0;
    end
    else
    begin
      wr_s_reg <= {wr_s_reg[1:0], wr_tgl_reg};
      rst_s_reg <= {rst_s_reg[1:0], rst_tgl_reg};
      rd_s_reg <= {rd_s_reg[1:0], rd_req_tgl_reg};
      seen_s_reg <= {seen_s_reg[1:0], seen_reg};
      wr_q_reg <= settle(wr_q_reg, wr_s_reg[1], wr_s_reg[2]);
      rst_q_reg <= settle(rst_q_reg, rst_s_reg[1], rst_s_reg[2]);
      rd_q_reg <= settle(rd_q_reg, rd_s_reg[1], rd_s_reg[2]);
      seen_q_reg <= settle(seen_q_reg, seen_s_reg[1], seen_s_reg[2]);
      wr_d_reg <= wr_q_reg;
      rst_d_reg <= rst_q_reg;
      rd_d_reg <= rd_q_reg;
    end
  end

  // --------------------------------------------------------------------
  // System domain: register write, readback and reset
  // --------------------------------------------------------------------
  logic reg_wr_en_reg;
  logic [7:0] reg_wr_addr_reg;
  logic [15:0] reg_wr_data_reg;
  logic soft_reset_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_wr_en_reg <= 1'b0;
      reg_wr_addr_reg <= 8'h00;
      reg_wr_data_reg <= 16'h0000;
      soft_reset_reg <= 1'b0;
    end
    else
    begin
      reg_wr_en_reg <= wr_q_reg ^ wr_d_reg; // R13
      soft_reset_reg <= rst_q_reg ^ rst_d_reg; // R10
      if (wr_q_reg ^ wr_d_reg)
      begin
        reg_wr_addr_reg <= wr_addr_hold_reg; // R12
        reg_wr_data_reg <= wr_data_hold_reg;
      end
    end
  end

  // Address is set first; data is taken one cycle later once it is valid
  logic [7:0] reg_rd_addr_reg;
  logic rd_pend_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rd_addr_reg <= 8'h00;
      rd_pend_reg <= 1'b0;
      rd_hold_reg <= 16'h0000;
      rd_ack_tgl_reg <= 1'b0;
    end
    else
    begin
      rd_pend_reg <= rd_q_reg ^ rd_d_reg;
      if (rd_q_reg ^ rd_d_reg)
        reg_rd_addr_reg <= cmd_reg; // R12
      if (rd_pend_reg)
      begin
        rd_hold_reg <= reg_rd_data;
        rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
      end
    end
  end

  // --------------------------------------------------------------------
  // System domain: host protocol lock
  // --------------------------------------------------------------------
  i2c_target_pkg::lock_state_type lock_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_reg <= i2c_target_pkg::LOCK_NONE;
      lock_en_reg <= 1'b0;
    end
    else
    begin
      lock_en_reg <= lock_reg != i2c_target_pkg::LOCK_OTHER;
      if (lock_reg == i2c_target_pkg::LOCK_NONE)
      begin
        if (seen_q_reg)
          lock_reg <= i2c_target_pkg::LOCK_I2C; // R18
        else if (other_protocol_seen)
          lock_reg <= i2c_target_pkg::LOCK_OTHER; // R18
      end
    end
  end

  logic sda_o_reg;
  logic locked_i2c_reg;
  logic locked_other_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_o_reg <= 1'b0;
      locked_i2c_reg <= 1'b0;
      locked_other_reg <= 1'b0;
    end
    else
    begin
      sda_o_reg <= 1'b0;
      locked_i2c_reg <= lock_reg == i2c_target_pkg::LOCK_I2C;
      locked_other_reg <= lock_reg == i2c_target_pkg::LOCK_OTHER;
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe = sda_oe_reg;
  assign reg_wr_en = reg_wr_en_reg;
  assign reg_wr_addr = reg_wr_addr_reg;
  assign reg_wr_data = reg_wr_data_reg;
  assign reg_rd_addr = reg_rd_addr_reg;
  assign soft_reset = soft_reset_reg;
  assign iface_locked_i2c = locked_i2c_reg;
  assign iface_locked_other = locked_other_reg;

endmodule // i2c_target_register_port

// ### testbench/i2c_ctrl_model.sv
// Behavioural two-wire bus controller facing the target port
`timescale 1ns/1ps

module i2c_ctrl_model (
  output logic scl, // Serial clock, owned by the controller
  output logic sda_low, // High while pulling data low
  input wire logic sda_in // Wired data level
);
  // --------
  // Bit timing
  // --------
  int q = 625; // Quarter bit: 400 kbps
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves mid-low so the target's sync delay never sees it near an edge
  task automatic bit_io(input logic b, output logic r);
    #q sda_low = !b;
    #q scl = 1'b1;
    #q r = sda_in;
    #q scl = 1'b0;
  endtask
  task automatic start_c();
    #q sda_low = 1'b0;
    #q scl = 1'b1;
    #q sda_low = 1'b1;
    #q scl = 1'b0;
  endtask
  task automatic stop_c();
    #q sda_low = 1'b1;
    #q scl = 1'b1;
    #q sda_low = 1'b0;
    #q;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // i2c_ctrl_model

// ### testbench/i2c_target_register_port_sva.sv
// Assertions bound to the two-wire target register port
`timescale 1ns/1ps

module i2c_target_register_port_sva #(
  parameter int LINK_CLK_KHZ = 8000
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic link_clk, // Line clock
  input wire logic scl_i, // Bus clock level
  input wire logic sda_o, // Data drive value
  input wire logic sda_oe, // Data pull enable
  input wire logic other_protocol_seen, // Other host seen
  input wire logic reg_wr_en, // Write strobe
  input wire logic [7:0] reg_wr_addr, // Write register
  input wire logic [15:0] reg_wr_data, // Write value
  input wire logic soft_reset, // Reset pulse
  input wire logic iface_locked_i2c, // Locked here
  input wire logic iface_locked_other // Locked elsewhere
);
  // --------
  // Line side
  // --------
  chk_oe_drives_low: assert property (@(posedge link_clk) disable iff (!rst_n) sda_oe |-> !sda_o)
    else $error("data driven high");
  chk_oe_scl_low: assert property (@(posedge link_clk) disable iff (!rst_n) $changed(sda_oe) |-> !scl_i)
    else $error("data moved with clock high");
  // --------
  // System side
  // --------
  chk_no_drive_other: assert property (@(posedge clk) disable iff (!rst_n) iface_locked_other |-> !sda_oe)
    else $error("bus driven while locked out");
  chk_wr_pulse_once: assert property (@(posedge clk) disable iff (!rst_n) reg_wr_en |=> !reg_wr_en)
    else $error("write strobe too long");
  chk_wr_held: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr_en |=> $stable(reg_wr_addr) && $stable(reg_wr_data))
    else $error("write value not held");
  chk_wr_needs_lock: assert property (@(posedge clk) disable iff (!rst_n) reg_wr_en |-> iface_locked_i2c)
    else $error("write while not locked");
  chk_reset_pulse: assert property (@(posedge clk) disable iff (!rst_n) soft_reset |=> !soft_reset)
    else $error("soft reset too long");
  chk_lock_excl: assert property (@(posedge clk) disable iff (!rst_n) !(iface_locked_i2c && iface_locked_other))
    else $error("both locks set");
  chk_i2c_sticky: assert property (@(posedge clk) disable iff (!rst_n) iface_locked_i2c |=> iface_locked_i2c)
    else $error("lock dropped");
  chk_other_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(iface_locked_other) |=> iface_locked_other [*8])
    else $error("other lock dropped");
  chk_other_lock: assert property (@(posedge clk) disable iff (!rst_n)
    other_protocol_seen && !iface_locked_i2c |-> ##[1:2] (iface_locked_other || iface_locked_i2c))
    else $error("other lock late");
endmodule // i2c_target_register_port_sva

bind i2c_target_register_port i2c_target_register_port_sva #(.LINK_CLK_KHZ(LINK_CLK_KHZ)) sva_u (
  .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .other_protocol_seen(other_protocol_seen), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data), .soft_reset(soft_reset), .iface_locked_i2c(iface_locked_i2c),
  .iface_locked_other(iface_locked_other)
);

// ### testbench/tb.sv
// Self-checking bench for the two-wire target register port
`timescale 1ns/1ps

module tb;
  typedef struct packed {logic [1:0] strap; logic [6:0] adr; logic ack; logic full; logic [7:0] cmd;
    logic [15:0] dat;} row_type;
  row_type rows [7] = '{'{2'h0, 7'h48, 1'b1, 1'b1, 8'h21, 16'hbeef}, '{2'h1, 7'h49, 1'b1, 1'b0, 8'h0, 16'h0},
    '{2'h2, 7'h4a, 1'b1, 1'b0, 8'h0, 16'h0}, '{2'h3, 7'h4b, 1'b1, 1'b0, 8'h0, 16'h0},
    '{2'h1, 7'h48, 1'b0, 1'b0, 8'h0, 16'h0}, '{2'h3, 7'h47, 1'b1, 1'b1, 8'h9c, 16'h0180},
    '{2'h0, 7'h78, 1'b0, 1'b0, 8'h0, 16'h0}};
  logic clk, link_clk, rst_n = 1'b0, other_protocol_seen = 1'b0, sda_o, sda_oe, reg_wr_en, soft_reset;
  logic scl_w, m_low, iface_locked_i2c, iface_locked_other, r;
  logic [1:0] strap = 2'h0;
  logic [7:0] reg_wr_addr, reg_rd_addr, d;
  logic [15:0] reg_wr_data, reg_rd_data;
  logic [23:0] wr_cnt = 24'h0, rst_cnt = 24'h0, wr_word = 24'h0, n;
  int fails = 0, compares = 0;
  wire sda_w;
  wire address_select_pin;
  // Open-drain data: either party pulls low, pull-up otherwise
  assign sda_w = !(m_low | (sda_oe & !sda_o));
  assign address_select_pin = strap == 2'h2 ? sda_w : strap == 2'h3 ? scl_w : strap[0];
  // Port takes read data the cycle after it moves the address
  assign reg_rd_data = {reg_rd_addr, ~reg_rd_addr};
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  i2c_ctrl_model m (.scl(scl_w), .sda_low(m_low), .sda_in(sda_w));
  i2c_target_register_port dut_u (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
    .other_protocol_seen(other_protocol_seen), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .soft_reset(soft_reset),
    .iface_locked_i2c(iface_locked_i2c), .iface_locked_other(iface_locked_other));
  // --------
  // Register file stand-in and strobe capture
  // --------
  always @(posedge clk)
  begin
    if (reg_wr_en === 1'b1)
    begin
      wr_cnt <= wr_cnt + 24'h1;
      wr_word <= {reg_wr_addr, reg_wr_data};
    end
    if (soft_reset === 1'b1)
      rst_cnt <= rst_cnt + 24'h1;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic [7:0] v, input logic exp);
    logic a;
    m.wr_byte(v, a);
    chk(24'(a), 24'(exp));
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Long wait after release covers the lock enable crossing
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (200) @(posedge clk);
  endtask
  task automatic pulse_other();
    @(posedge clk);
    other_protocol_seen <= 1'b1;
    @(posedge clk);
    other_protocol_seen <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    #750000;
    fails++;
    close_out();
  end
  // --------
  // Main sequence
  // --------
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      @(posedge clk);
      strap <= rows[i].strap;
      n = wr_cnt;
      m.start_c();
      wb({rows[i].adr, 1'b0}, rows[i].ack);
      if (rows[i].full)
      begin
        wb(rows[i].cmd, 1'b1);
        wb(rows[i].dat[15:8], 1'b1);
        wb(rows[i].dat[7:0], 1'b1);
      end
      m.stop_c();
      chk(wr_cnt, n + 24'(rows[i].full));
      if (rows[i].full)
        chk(wr_word, {rows[i].cmd, rows[i].dat});
    end
    // Aborted byte, then a read through repeated start
    @(posedge clk);
    strap <= 2'h0;
    m.start_c();
    repeat (3) m.bit_io(1'b0, r);
    m.start_c();
    wb(8'h90, 1'b1);
    wb(8'h5a, 1'b1);
    m.start_c();
    wb(8'h91, 1'b1);
    m.rd_byte(1'b0, d);
    chk(24'(d), 24'h5a);
    m.rd_byte(1'b1, d);
    chk(24'(d), 24'ha5);
    m.stop_c();
    chk(24'(sda_oe), 24'h0);
    m.start_c();
    wb(8'h8f, 1'b0);
    m.stop_c();
    n = rst_cnt;
    m.start_c();
    wb(8'h00, 1'b1);
    wb(8'h07, 1'b0);
    m.stop_c();
    m.start_c();
    wb(8'h00, 1'b1);
    wb(8'h06, 1'b1);
    chk(rst_cnt, n + 24'h1);
    m.stop_c();
    pulse_other();
    chk(24'({iface_locked_i2c, iface_locked_other}), 24'h2);
    do_reset();
    chk(24'({sda_oe, reg_wr_en, soft_reset, iface_locked_i2c, iface_locked_other}), 24'h0);
    pulse_other();
    chk(24'({iface_locked_i2c, iface_locked_other}), 24'h1);
    m.start_c();
    wb(8'h90, 1'b0);
    m.stop_c();
    close_out();
  end
endmodule // tb
